// file: design/poc_power_output_ctrl.sv
// Behaviour
// - bandwidth bit: 0 low, 1 high, default 1
// - power-down select: 0 manual, 1 automatic
// - automatic: powered while hsync or sog active
// - manual: register bit or active pin powers down
// - pin polarity bit: 0 low, 1 high active
// - fast switching keeps power, floats outputs only
// - sog pd bit floats sync output in power-down
// - mode field: 00 rgb, 01 422, 10 ddr
// - 422 uses 16 pins; ddr changes every edge
// - primary enable floats or drives, default 1
// - blue carries secondary in 422 and ddr
// - secondary enable floats or drives, default 0
// - drive strength field, default 10, some excluded
// - clock invert bit, default 0
// - clock select: pixel, 90 deg, 2x, 40 MHz
// - global hiz floats all but sync slicer output
// - sog hiz bit floats sync slicer output
// - field polarity bit, default 1
// - steady sync input is reported inactive
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module poc_power_output_ctrl
  import poc_pkg::*;
#(
  parameter int unsigned ACT_WINDOW = ACT_WINDOW_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sync activity inputs and power pin
  input wire poc_sync_t sync_in,
  input wire logic power_down_pin,
  // digitizer data path inputs
  input wire poc_pixel_t pixel_in,
  input wire logic sync_on_green_input,
  input wire logic vsync_in,
  input wire logic odd_field_in,
  // analog core control
  output logic core_power_down,
  output logic bandwidth_high,
  output logic [1:0] drive_strength,
  // output pins with enables
  output poc_pixel_t data_out,
  output logic red_green_oe,
  output logic blue_oe,
  output logic clock_out,
  output logic clock_out_oe,
  output logic green_sync_slicer_output,
  output logic green_sync_slicer_output_oe,
  output logic vertical_sync_output,
  output logic vertical_sync_output_oe,
  output logic field_output,
  output logic field_output_oe
);

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_FAST_HIZ,
    ST_POWERED_DOWN
  } poc_pwr_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] input_and_power_control;
  logic [7:0] output_control;
  logic [7:0] output_clock_and_impedance;
  logic [7:0] detect_status;
  logic [31:0] rdata;
  logic answered;

  wire logic [7:0] reg_index = paddr[ADDR_W-1:2];
  wire logic hit_input_power = reg_index == IDX_INPUT_POWER;
  wire logic hit_output_ctrl = reg_index == IDX_OUTPUT_CTRL;
  wire logic hit_clock_hiz = reg_index == IDX_CLOCK_HIZ;
  wire logic hit_detect = reg_index == IDX_DETECT;
  wire logic hit_any = hit_input_power | hit_output_ctrl | hit_clock_hiz
    | hit_detect;
  // the status register is read-only: writing it is refused
  wire logic bad_access = !hit_any | (pwrite & hit_detect);
  wire logic setup = psel & !penable;
  wire logic access_done = psel & penable & pready;
  wire logic do_write = access_done & pwrite & !bad_access;
  wire logic [7:0] read_mux = hit_input_power ? input_and_power_control :
    hit_output_ctrl ? output_control :
    hit_clock_hiz ? output_clock_and_impedance :
    hit_detect ? detect_status : 8'h00;

  assign pready = answered;
  assign prdata = rdata;

  // answer always in the first access cycle; read data is latched in setup
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      answered <= 1'b0;
      rdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      answered <= 1'b1;
      rdata <= {24'h00_0000, read_mux};
      pslverr <= bad_access;
    end else if (access_done) begin
      answered <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      input_and_power_control <= RST_INPUT_POWER;
      output_control <= RST_OUTPUT_CTRL;
      output_clock_and_impedance <= RST_CLOCK_HIZ;
    end else if (do_write) begin
      if (hit_input_power)
        input_and_power_control <= pwdata[7:0] & MASK_INPUT_POWER;
      if (hit_output_ctrl)
        output_control <= pwdata[7:0] & MASK_OUTPUT_CTRL;
      if (hit_clock_hiz)
        output_clock_and_impedance <= pwdata[7:0] & MASK_CLOCK_HIZ;
    end
  end

  wire logic pd_auto = input_and_power_control[BIT_PD_AUTO];
  wire logic pd_soft = input_and_power_control[BIT_PD];
  wire logic pd_pin_high = input_and_power_control[BIT_PD_POL];
  wire logic fast_switch = input_and_power_control[BIT_FAST];
  wire logic sog_pd_hiz = input_and_power_control[BIT_SOG_PD_HIZ];
  wire poc_mode_t out_mode = poc_mode_t'(output_control[MODE_LSB+:2]);
  wire logic primary_en = output_control[BIT_PRI_EN];
  wire logic secondary_en = output_control[BIT_SEC_EN];
  wire logic clk_invert = output_control[BIT_CLK_INV];
  wire poc_clksel_t clk_sel =
    poc_clksel_t'(output_clock_and_impedance[CLKSEL_LSB+:2]);
  wire logic all_hiz = output_clock_and_impedance[BIT_ALL_HIZ];
  wire logic sog_hiz = output_clock_and_impedance[BIT_SOG_HIZ];
  wire logic field_pol = output_clock_and_impedance[BIT_FIELD_POL];

  assign bandwidth_high = input_and_power_control[BIT_BW_HIGH];
  // vsync and field outputs keep a fixed drive
  assign drive_strength = output_control[DRV_LSB+:2];

  ////////////////////////////////////////////////////////////////////////////
  // activity detectors: an edge restarts the window, silence ends it

  genvar gi;
  generate
    for (gi = 0; gi < $bits(poc_sync_t); gi++) begin : g_detect
      logic last;
      logic [$clog2(ACT_WINDOW+1)-1:0] quiet;
      wire logic edge_seen = sync_in[gi] ^ last;
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          last <= 1'b0;
          quiet <= '0;
          detect_status[gi] <= 1'b0;
        end else begin
          last <= sync_in[gi];
          if (edge_seen) begin
            quiet <= '0;
            detect_status[gi] <= 1'b1;
          end else if (quiet == ($bits(quiet))'(ACT_WINDOW - 1)) begin
            detect_status[gi] <= 1'b0;
          end else begin
            quiet <= quiet + 1'b1;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // power management

  poc_pwr_state_t pwr_state, next_pwr_state;
  wire poc_sync_t det = poc_sync_t'(detect_status);
  // hsync or sync-on-green on either channel keeps the part awake
  wire logic sync_present = det.hsync0 | det.hsync1 | det.sog0 | det.sog1;
  wire logic pin_active = pd_pin_high ? power_down_pin : !power_down_pin;
  wire logic manual_pd = pd_soft | pin_active;
  wire logic pd_request = pd_auto ? !sync_present : manual_pd;

  always_comb begin
    next_pwr_state = ST_ACTIVE;
    case (1'b1)
      !pd_request: next_pwr_state = ST_ACTIVE;
      fast_switch: next_pwr_state = ST_FAST_HIZ;
      default: next_pwr_state = ST_POWERED_DOWN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      pwr_state <= ST_ACTIVE;
    else
      pwr_state <= next_pwr_state;
  end

  // fast switching keeps the analog core live so resume is instant
  assign core_power_down = pwr_state == ST_POWERED_DOWN;
  wire logic in_pd = pwr_state != ST_ACTIVE;
  wire logic drive_ok = !in_pd & !all_hiz;

  ////////////////////////////////////////////////////////////////////////////
  // output clocks: pixel rate is a quarter of ref_clk

  logic [1:0] phase;
  logic [ACC_W-1:0] acc;
  logic fixed_clk;
  wire logic [ACC_W-1:0] acc_sum = acc + ACC_STEP;
  wire logic acc_wrap = acc_sum >= ACC_WRAP;
  wire logic pixel_en = phase == 2'h3;
  wire logic half_en = phase[0];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 2'h0;
      acc <= '0;
      fixed_clk <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      acc <= acc_wrap ? acc_sum - ACC_WRAP : acc_sum;
      // average rate exact, edges jitter by one ref_clk period
      if (acc_wrap)
        fixed_clk <= !fixed_clk;
    end
  end

  logic sel_clk;
  always_comb begin
    case (clk_sel)
      CLK_PIXEL: sel_clk = phase[1];
      CLK_PIXEL_90: sel_clk = phase[1] ^ phase[0];
      CLK_PIXEL_2X: sel_clk = phase[0];
      CLK_FIXED: sel_clk = fixed_clk;
      default: sel_clk = phase[1];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // output formatter

  wire logic ddr = out_mode == MODE_DDR444;
  wire logic split = out_mode == MODE_YCC422 | ddr;
  // ddr updates the data on both halves of the output clock
  wire logic load_pix = ddr ? half_en : pixel_en;
  wire logic next_rg_oe = drive_ok & primary_en;
  // 422 frees the blue lanes: only the secondary stream may use them
  wire logic next_blue_oe = drive_ok
    & (split ? secondary_en : primary_en);
  wire logic next_sog_oe = !sog_hiz
    & !(in_pd & sog_pd_hiz);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= '0;
      clock_out <= 1'b0;
      green_sync_slicer_output <= 1'b0;
      vertical_sync_output <= 1'b0;
      field_output <= 1'b0;
    end else begin
      if (load_pix)
        data_out <= pixel_in;
      clock_out <= sel_clk ^ clk_invert;
      green_sync_slicer_output <= sync_on_green_input;
      vertical_sync_output <= vsync_in;
      field_output <= odd_field_in ^ field_pol;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      red_green_oe <= 1'b0;
      blue_oe <= 1'b0;
      clock_out_oe <= 1'b0;
      green_sync_slicer_output_oe <= 1'b0;
      vertical_sync_output_oe <= 1'b0;
      field_output_oe <= 1'b0;
    end else begin
      red_green_oe <= next_rg_oe;
      blue_oe <= next_blue_oe;
      clock_out_oe <= drive_ok;
      green_sync_slicer_output_oe <= next_sog_oe;
      vertical_sync_output_oe <= drive_ok;
      field_output_oe <= drive_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // checks start one edge after reset ends: release lands on a clock edge
  logic chk_live;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      chk_live <= 1'b0;
    else
      chk_live <= 1'b1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!chk_live);

  sequence s_write_pd_hi;
    do_write && hit_input_power && pwdata[BIT_PD] && !pwdata[BIT_PD_AUTO]
      && !pwdata[BIT_FAST];
  endsequence

  chk_soft_pd_forces: assert property (
    s_write_pd_hi |=> ##1 core_power_down ##1 !red_green_oe)
    else $error("power-down bit did not force power-down");

  chk_auto_wake: assert property (
    pd_auto && sync_present |=> pwr_state == ST_ACTIVE)
    else $error("auto control powered down with sync present");

  chk_pin_polarity: assert property (
    !pd_auto && !pd_soft && (power_down_pin == pd_pin_high)
      |=> pwr_state != ST_ACTIVE)
    else $error("active power-down pin ignored");

  chk_fast_keeps_power: assert property (
    pd_request && fast_switch |=> !core_power_down ##1 !red_green_oe)
    else $error("fast switching lost power or kept outputs driven");

  chk_global_hiz: assert property (
    all_hiz [*2] |-> !clock_out_oe && !field_output_oe
      && green_sync_slicer_output_oe == $past(next_sog_oe))
    else $error("global hiz wrong on outputs");

  chk_blue_in_split: assert property (
    $stable(output_control) && split && !secondary_en [*2]
      |-> !blue_oe)
    else $error("blue lanes driven without secondary enable");

  chk_ddr_update: assert property (
    ddr && half_en && $stable(output_control) |=> data_out == $past(pixel_in))
    else $error("ddr data not updated on half edge");

  chk_field_pol: assert property (
    1'b1 |=> field_output == ($past(odd_field_in) ^ $past(field_pol)))
    else $error("field output polarity wrong");

  chk_detect_quiet: assert property (
    $stable(sync_in) [*8] ##1 detect_status[7] && g_detect[7].quiet == '0
      |-> 1'b0)
    else $error("hsync detect window restarted without an edge");

  chk_bus_answer: assert property (
    setup |=> pready && prdata == {24'h00_0000, $past(read_mux)})
    else $error("apb read not answered in first access cycle");

endmodule // poc_power_output_ctrl
`default_nettype wire

// file: design/poc_pkg.sv
`default_nettype none
package poc_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_INPUT_POWER = 8'h1e;
  localparam logic [7:0] IDX_OUTPUT_CTRL = 8'h1f;
  localparam logic [7:0] IDX_CLOCK_HIZ = 8'h20;
  localparam logic [7:0] IDX_DETECT = 8'h24;

  // input_and_power_control fields
  localparam int unsigned BIT_BW_HIGH = 5;
  localparam int unsigned BIT_PD_AUTO = 4;
  localparam int unsigned BIT_PD = 3;
  localparam int unsigned BIT_PD_POL = 2;
  localparam int unsigned BIT_FAST = 1;
  localparam int unsigned BIT_SOG_PD_HIZ = 0;
  // output_control fields
  localparam int unsigned MODE_LSB = 5;
  localparam int unsigned BIT_PRI_EN = 4;
  localparam int unsigned BIT_SEC_EN = 3;
  localparam int unsigned DRV_LSB = 1;
  localparam int unsigned BIT_CLK_INV = 0;
  // output_clock_and_impedance fields
  localparam int unsigned CLKSEL_LSB = 6;
  localparam int unsigned BIT_ALL_HIZ = 5;
  localparam int unsigned BIT_SOG_HIZ = 4;
  localparam int unsigned BIT_FIELD_POL = 3;

  // power-up values and writable bits
  localparam logic [7:0] RST_INPUT_POWER = 8'h20;
  localparam logic [7:0] RST_OUTPUT_CTRL = 8'h14;
  localparam logic [7:0] RST_CLOCK_HIZ = 8'h08;
  localparam logic [7:0] MASK_INPUT_POWER = 8'h3f;
  localparam logic [7:0] MASK_OUTPUT_CTRL = 8'h7f;
  localparam logic [7:0] MASK_CLOCK_HIZ = 8'hf8;

  // timing
  localparam int unsigned REF_CLK_KHZ = 125000;
  localparam int unsigned FIXED_CLK_KHZ = 40000;
  localparam int unsigned ACT_WINDOW_US = 100;
  localparam int unsigned ACT_WINDOW_CYCLES =
    ACT_WINDOW_US * REF_CLK_KHZ / 1000;
  // one bit above the largest acc so acc + step never wraps
  localparam int unsigned ACC_W = 18;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(2 * FIXED_CLK_KHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(REF_CLK_KHZ);

  typedef enum logic [1:0] {
    MODE_RGB444 = 2'h0,
    MODE_YCC422 = 2'h1,
    MODE_DDR444 = 2'h2
  } poc_mode_t;

  typedef enum logic [1:0] {
    CLK_PIXEL = 2'h0,
    CLK_PIXEL_90 = 2'h1,
    CLK_PIXEL_2X = 2'h2,
    CLK_FIXED = 2'h3
  } poc_clksel_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } poc_pixel_t;

  // field order matches the detect status bits 7..0
  typedef struct packed {
    logic hsync0;
    logic hsync1;
    logic vsync0;
    logic vsync1;
    logic sog0;
    logic sog1;
    logic coast;
    logic clamp;
  } poc_sync_t;

endpackage
`default_nettype wire

// file: tb/poc_display_sink.sv
`timescale 1ns/1ps
`default_nettype none
module poc_display_sink
  import poc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // pins seen by the display controller
  input wire logic clock_out,
  input wire logic clock_out_oe,
  input wire poc_pixel_t data_out,
  input wire logic red_green_oe,
  // capture results
  output int edge_count,
  output poc_pixel_t last_pixel
);
  logic prev_clk;
  // a floated clock pin gives the sink no edges at all
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_clk <= 1'b0;
      edge_count <= 0;
      last_pixel <= '0;
    end else begin
      prev_clk <= clock_out & clock_out_oe;
      if (clock_out & clock_out_oe & !prev_clk) begin
        edge_count <= edge_count + 1;
        if (red_green_oe) begin
          last_pixel <= data_out;
        end
      end
    end
  end
endmodule // poc_display_sink
`default_nettype wire

// file: tb/power_and_output_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module power_and_output_control_tb_top;
  import poc_pkg::*;
  localparam logic [9:0] A_IP = {IDX_INPUT_POWER, 2'b00};
  localparam logic [9:0] A_OC = {IDX_OUTPUT_CTRL, 2'b00};
  localparam logic [9:0] A_CH = {IDX_CLOCK_HIZ, 2'b00};
  localparam logic [9:0] A_ST = {IDX_DETECT, 2'b00};
  logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  poc_sync_t sync_in;
  poc_pixel_t pixel_in, data_out, last_pixel;
  logic power_down_pin, sync_on_green_input, vsync_in, odd_field_in;
  logic core_power_down, bandwidth_high, red_green_oe, blue_oe;
  logic [1:0] drive_strength;
  logic clock_out, clock_out_oe, green_sync_slicer_output;
  logic green_sync_slicer_output_oe, vertical_sync_output;
  logic vertical_sync_output_oe, field_output, field_output_oe;
  int edge_count;
  int fail_count = 0;
  int n_checks = 0;

  poc_power_output_ctrl #(.ACT_WINDOW(16)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_in(sync_in),
    .power_down_pin(power_down_pin), .pixel_in(pixel_in),
    .sync_on_green_input(sync_on_green_input), .vsync_in(vsync_in),
    .odd_field_in(odd_field_in), .core_power_down(core_power_down),
    .bandwidth_high(bandwidth_high), .drive_strength(drive_strength),
    .data_out(data_out), .red_green_oe(red_green_oe), .blue_oe(blue_oe),
    .clock_out(clock_out), .clock_out_oe(clock_out_oe),
    .green_sync_slicer_output(green_sync_slicer_output),
    .green_sync_slicer_output_oe(green_sync_slicer_output_oe),
    .vertical_sync_output(vertical_sync_output),
    .vertical_sync_output_oe(vertical_sync_output_oe),
    .field_output(field_output), .field_output_oe(field_output_oe));

  poc_display_sink sink_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .clock_out(clock_out),
    .clock_out_oe(clock_out_oe), .data_out(data_out),
    .red_green_oe(red_green_oe), .edge_count(edge_count),
    .last_pixel(last_pixel));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // apb master: request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      end_sim();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string nm, input logic [9:0] a,
                     input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(nm, x, r);
    chk({nm, " err"}, {31'h0, xe}, {31'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    logic [31:0] r;
    logic e;
    rdc("input power", A_IP, 32'h20, 1'b0);
    rdc("output ctrl", A_OC, 32'h14, 1'b0);
    rdc("clock hiz", A_CH, 32'h08, 1'b0);
    chk("bw high", 32'h1, {31'h0, bandwidth_high});
    chk("drive", 32'h2, {30'h0, drive_strength});
    rdc("unmapped", 10'h084, 32'h0, 1'b1);
    apb(1'b1, A_ST, 8'hff, r, e);
    chk("status write err", 32'h1, {31'h0, e});
    $display("test defaults done");
  endtask

  task automatic t_manual();
    // {register, pin, core down, data oe, slicer oe}
    logic [11:0] rows[7] = '{{8'h24, 4'b0011}, {8'h24, 4'b1101},
      {8'h20, 4'b1011}, {8'h20, 4'b0101}, {8'h2c, 4'b0101},
      {8'h2d, 4'b0100}, {8'h2e, 4'b1001}};
    foreach (rows[i]) begin
      @(posedge ref_clk);
      power_down_pin <= rows[i][3];
      wr(A_IP, rows[i][11:4]);
      settle(4);
      chk("core pd", {31'h0, rows[i][2]}, {31'h0, core_power_down});
      chk("rg oe", {31'h0, rows[i][1]}, {31'h0, red_green_oe});
      chk("slicer oe", {31'h0, rows[i][0]},
          {31'h0, green_sync_slicer_output_oe});
    end
    $display("test manual done");
  endtask

  task automatic t_auto();
    int idx[3] = '{7, 3, 5};
    logic [7:0] m;
    @(posedge ref_clk);
    power_down_pin <= 1'b0;
    wr(A_IP, 8'h34);
    settle(24);
    chk("idle pd", 32'h1, {31'h0, core_power_down});
    foreach (idx[i]) begin
      m = 8'h1 << idx[i];
      fork
        repeat (16) begin
          repeat (4) @(posedge ref_clk);
          sync_in <= poc_sync_t'(sync_in ^ m);
        end
        begin
          settle(20);
          chk("active pd", {31'h0, idx[i] == 5},
              {31'h0, core_power_down});
          rdc("status", A_ST, {24'h0, m}, 1'b0);
        end
      join
      settle(40);
      rdc("status steady", A_ST, 32'h0, 1'b0);
      chk("steady pd", 32'h1, {31'h0, core_power_down});
    end
    wr(A_IP, 8'h04);
    settle(1);
    chk("bw low", 32'h0, {31'h0, bandwidth_high});
    $display("test auto done");
  endtask

  task automatic t_outputs();
    wr(A_OC, 8'h36);
    settle(3);
    chk("drive", 32'h3, {30'h0, drive_strength});
    chk("blue oe", 32'h0, {31'h0, blue_oe});
    chk("rg oe", 32'h1, {31'h0, red_green_oe});
    wr(A_OC, 8'h5c);
    settle(3);
    chk("blue oe", 32'h1, {31'h0, blue_oe});
    wr(A_OC, 8'h04);
    settle(3);
    chk("rg oe", 32'h0, {31'h0, red_green_oe});
    chk("blue oe", 32'h0, {31'h0, blue_oe});
    wr(A_OC, 8'h14);
    @(posedge ref_clk);
    odd_field_in <= 1'b1;
    vsync_in <= 1'b1;
    sync_on_green_input <= 1'b1;
    wr(A_CH, 8'h28);
    settle(3);
    chk("rg oe", 32'h0, {31'h0, red_green_oe});
    chk("clk oe", 32'h0, {31'h0, clock_out_oe});
    chk("slicer oe", 32'h1,
        {31'h0, green_sync_slicer_output_oe});
    chk("field", 32'h0, {31'h0, field_output});
    chk("vs oe", 32'h0, {31'h0, vertical_sync_output_oe});
    chk("field oe", 32'h0, {31'h0, field_output_oe});
    chk("slicer", 32'h1, {31'h0, green_sync_slicer_output});
    wr(A_CH, 8'h10);
    settle(3);
    chk("slicer oe", 32'h0,
        {31'h0, green_sync_slicer_output_oe});
    chk("rg oe", 32'h1, {31'h0, red_green_oe});
    chk("field", 32'h1, {31'h0, field_output});
    chk("vs oe", 32'h1, {31'h0, vertical_sync_output_oe});
    chk("vs", 32'h1, {31'h0, vertical_sync_output});
    $display("test outputs done");
  endtask

  task automatic t_clock();
    int exp_e[4] = '{16, 16, 32, 20};
    int c0;
    int d;
    int n;
    @(posedge ref_clk);
    pixel_in <= 24'h3c5a7e;
    for (int s = 0; s < 4; s++) begin
      wr(A_CH, {2'(s), 6'h08});
      settle(8);
      c0 = edge_count;
      repeat (64) @(negedge ref_clk);
      d = edge_count - c0;
      chk("clk edges", 32'h1,
          {31'h0, d >= exp_e[s] - 1 && d <= exp_e[s] + 1});
    end
    chk("pixel", 32'h3c5a7e, {8'h0, last_pixel});
    // pixel clock is high in the cycle new data appears, low when inverted
    wr(A_CH, 8'h08);
    for (int v = 0; v < 2; v++) begin
      wr(A_OC, {7'h0a, v[0]});
      @(posedge ref_clk);
      pixel_in <= {23'h0, v[0]};
      n = 0;
      do begin
        @(negedge ref_clk);
        n++;
      end while (data_out !== {23'h0, v[0]} && n < 8);
      chk("pixel load", {31'h0, v[0]}, {8'h0, data_out});
      chk("clk at load", {31'h0, !v[0]}, {31'h0, clock_out});
    end
    $display("test clock done");
  endtask

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sync_in = '0;
    pixel_in = '0;
    power_down_pin = 1'b0;
    sync_on_green_input = 1'b0;
    vsync_in = 1'b0;
    odd_field_in = 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_defaults();
    t_manual();
    t_auto();
    t_outputs();
    t_clock();
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end
endmodule // power_and_output_control_tb_top
`default_nettype wire
